// ===== hw/sadc_pkg.sv
// Shared constants for the successive-approximation converter sequencer
package sadc_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [7:0] SCR_OFF = 8'h38;
  localparam logic [7:0] RES_OFF = 8'h3c;
  localparam logic [7:0] CLK_OFF = 8'h40;
  localparam logic [7:0] PDAT_OFF = 8'h44;
  localparam logic [7:0] PDIR_OFF = 8'h48;
  localparam logic [7:0] PPIN_OFF = 8'h4c;
  // Status and control field positions
  localparam int DONE_BIT = 7;
  localparam int IEN_BIT = 6;
  localparam int CONT_BIT = 5;
  localparam int SEL_W = 5;
  // Input select codes
  localparam logic [4:0] SEL_POWER_OFF = 5'h1f;
  localparam logic [4:0] SEL_RST = 5'h1f;
  localparam int NUM_PINS = 15;
  // Clock register field positions and reset
  localparam int PRE_LSB = 5;
  localparam int PRE_W = 3;
  localparam int SRC_BIT = 4;
  localparam logic [3:0] CLK_RST = 4'h0;
  // Conversion length in converter clocks
  localparam logic [4:0] CONV_TICKS = 5'h10;
  localparam logic [3:0] LAST_STEP = 4'hf;
  localparam logic [7:0] RES_RST = 8'h00;
  localparam logic [7:0] SAR_FIRST = 8'h80;
endpackage

// ===== hw/sadc_prescaler.sv
// Converter clock source select and prescaler, as a tick on the bus clock
`timescale 1ns/1ps
module sadc_prescaler (
  input wire logic mclk_i, // Bus clock
  input wire logic rst_b_i, // Sync reset, active low
  input wire logic xtal_i, // Crystal reference clock level
  input wire logic src_bus_i, // 1 = bus clock, 0 = crystal
  input wire logic [2:0] prescale_i, // Divide code
  input wire logic hold_i, // Freeze the divider
  output logic tick_o // One converter clock edge
);
  logic xtal_d_reg;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [3:0] lim;
  logic in_tick;

  assign in_tick = src_bus_i | (xtal_i & ~xtal_d_reg);
  assign lim = prescale_i[2] ? 4'hf : 4'((4'h1 << prescale_i[1:0]) - 4'h1);
  assign tick_o = in_tick & ~hold_i & (cnt_reg >= lim);
  assign cnt_next = tick_o ? 4'h0 : (in_tick & ~hold_i ? 4'(cnt_reg + 4'h1) : cnt_reg);

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      xtal_d_reg <= 1'b0;
      cnt_reg <= 4'h0;
    end else begin
      xtal_d_reg <= xtal_i;
      cnt_reg <= cnt_next;
    end
  end

  div_bound_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (tick_o && $past(tick_o) && $stable(prescale_i)) |-> (lim == 4'h0))
    else $error("converter tick faster than the prescale allows");
endmodule // sadc_prescaler

// ===== hw/sadc_sar.sv
// Successive-approximation step engine, sixteen converter clocks per result
`timescale 1ns/1ps
module sadc_sar (
  input wire logic mclk_i, // Bus clock
  input wire logic rst_b_i, // Sync reset, active low
  input wire logic tick_i, // Converter clock edge
  input wire logic start_i, // Begin at this tick
  input wire logic abort_i, // Drop any conversion
  input wire logic comp_i, // 1 when input at or above trial
  output logic busy_o, // Conversion running
  output logic done_o, // One-cycle completion pulse
  output logic [7:0] result_o, // Last completed code
  output logic [7:0] dac_o // Trial code to comparator
);
  logic [3:0] step_reg;
  logic [7:0] trial_next;
  logic [2:0] idx;
  logic [4:0] seen_reg;

  assign idx = 3'(3'h7 - step_reg[2:0]);
  always_comb begin
    trial_next = dac_o;
    if (!step_reg[3]) begin
      trial_next[idx] = comp_i;
      if (idx != 3'h0) begin
        trial_next[3'(idx - 3'h1)] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i || abort_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      step_reg <= 4'h0;
      dac_o <= sadc_pkg::RES_RST;
    end else begin
      done_o <= tick_i & busy_o & (step_reg == sadc_pkg::LAST_STEP);
      if (tick_i && !busy_o && start_i) begin
        busy_o <= 1'b1;
        step_reg <= 4'h0;
        dac_o <= sadc_pkg::SAR_FIRST;
      end else if (tick_i && busy_o) begin
        dac_o <= trial_next;
        step_reg <= 4'(step_reg + 4'h1);
        busy_o <= step_reg != sadc_pkg::LAST_STEP;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      result_o <= sadc_pkg::RES_RST;
    end else if (tick_i && busy_o && step_reg == sadc_pkg::LAST_STEP) begin
      result_o <= dac_o;
    end
  end

  // Helper count of converter clocks since start
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      seen_reg <= 5'h0;
    end else if (tick_i && !busy_o && start_i) begin
      // The start edge opens the count; sixteen clocks follow it, eight deciding bits and eight holding the code
      seen_reg <= 5'h0;
    end else if (tick_i && busy_o) begin
      seen_reg <= 5'(seen_reg + 5'h1);
    end
  end

  conv_length_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    done_o |-> (seen_reg == sadc_pkg::CONV_TICKS))
    else $error("conversion did not take sixteen converter clocks");
endmodule // sadc_sar

// ===== hw/sadc_top.sv
// Converter sequencer: register slave, pin claim, start/stop control
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module sadc_top #(
  parameter int NPIN = sadc_pkg::NUM_PINS // Shared port pins
) (
  input wire logic mclk_i, // Bus clock, 125 MHz
  input wire logic rst_b_i, // Sync reset, active low
  input wire logic [7:0] avs_address_i, // Byte address
  input wire logic avs_read_i, // Read request
  input wire logic avs_write_i, // Write request
  input wire logic [3:0] avs_byteenable_i, // Byte lanes
  input wire logic [31:0] avs_writedata_i, // Write data
  output logic [31:0] avs_readdata_o, // Read data
  output logic avs_waitrequest_o, // Stall
  input wire logic xtal_i, // Crystal reference clock
  input wire logic stop_i, // Processor stop mode
  input wire logic comp_i, // Comparator: input at or above trial
  output logic [7:0] dac_code_o, // Trial code to comparator
  output logic [4:0] mux_sel_o, // Analog multiplexer select
  output logic conv_power_o, // Analog section powered
  output logic irq_o, // Interrupt request, also wake
  input wire logic [NPIN-1:0] pin_in_i, // Pin levels
  output logic [NPIN-1:0] pin_out_o, // Pin drive values
  output logic [NPIN-1:0] pin_oe_o // Pin drive enables
);
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic done_reg;
  logic ien_reg;
  logic cont_reg;
  logic [4:0] sel_reg;
  logic [3:0] clkcfg_reg;
  logic [NPIN-1:0] pdat_reg;
  logic [NPIN-1:0] pdir_reg;
  logic pend_reg;
  logic irq_reg;
  logic [NPIN-1:0] claimed;
  logic [NPIN-1:0] pin_rd;
  logic req;
  logic acc_wr;
  logic acc_rd;
  logic lane0;
  logic hit_scr;
  logic hit_res;
  logic hit_clk;
  logic hit_pdat;
  logic hit_pdir;
  logic hit_ppin;
  logic scr_wr;
  logic res_rd;
  logic tick;
  logic busy;
  logic sar_done;
  logic [7:0] result;
  logic powered;
  logic flag_clr;
  logic [7:0] scr_view;
  logic [31:0] rmux;

  // Bus decode
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_reg;
  assign acc_wr = avs_write_i & ack_reg;
  assign acc_rd = avs_read_i & ack_reg;
  assign lane0 = avs_byteenable_i[0];
  assign hit_scr = avs_address_i == sadc_pkg::SCR_OFF;
  assign hit_res = avs_address_i == sadc_pkg::RES_OFF;
  assign hit_clk = avs_address_i == sadc_pkg::CLK_OFF;
  assign hit_pdat = avs_address_i == sadc_pkg::PDAT_OFF;
  assign hit_pdir = avs_address_i == sadc_pkg::PDIR_OFF;
  assign hit_ppin = avs_address_i == sadc_pkg::PPIN_OFF;
  assign scr_wr = acc_wr & lane0 & hit_scr;
  assign res_rd = acc_rd & hit_res;
  assign flag_clr = scr_wr | res_rd;
  assign avs_readdata_o = rdata_reg;

  assign powered = sel_reg != sadc_pkg::SEL_POWER_OFF;
  assign conv_power_o = powered;
  assign mux_sel_o = sel_reg;
  assign irq_o = irq_reg;

  // flag reads 0 while interrupts enabled
  assign scr_view = {done_reg & ~ien_reg, ien_reg, cont_reg, sel_reg};

  // Pin claim and read values
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      assign claimed[gi] = sel_reg == 5'(gi);
      assign pin_oe_o[gi] = pdir_reg[gi] & ~claimed[gi];
      assign pin_out_o[gi] = pdat_reg[gi];
      assign pin_rd[gi] = pdir_reg[gi] ? pdat_reg[gi] : (~claimed[gi] & pin_in_i[gi]);
    end
  endgenerate

  assign rmux = hit_scr ? {24'h0, scr_view} :
                hit_res ? {24'h0, result} :
                hit_clk ? {24'h0, clkcfg_reg, 4'h0} :
                hit_pdat ? 32'(pdat_reg) :
                hit_pdir ? 32'(pdir_reg) :
                hit_ppin ? 32'(pin_rd) : 32'h0;

  // One wait state per access
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      ack_reg <= req & ~ack_reg;
      rdata_reg <= (avs_read_i & ~ack_reg) ? rmux : rdata_reg;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      ien_reg <= 1'b0;
      cont_reg <= 1'b0;
      sel_reg <= sadc_pkg::SEL_RST;
    end else if (scr_wr) begin
      ien_reg <= avs_writedata_i[sadc_pkg::IEN_BIT];
      cont_reg <= avs_writedata_i[sadc_pkg::CONT_BIT];
      sel_reg <= avs_writedata_i[sadc_pkg::SEL_W-1:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      clkcfg_reg <= sadc_pkg::CLK_RST;
    end else if (acc_wr && lane0 && hit_clk) begin
      clkcfg_reg <= avs_writedata_i[sadc_pkg::PRE_LSB+sadc_pkg::PRE_W-1:sadc_pkg::SRC_BIT];
    end
  end

  // selected pin keeps its port bits
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      pdat_reg <= '0;
      pdir_reg <= '0;
    end else begin
      if (acc_wr && hit_pdat) begin
        pdat_reg <= (avs_writedata_i[NPIN-1:0] & ~claimed) | (pdat_reg & claimed);
      end
      if (acc_wr && hit_pdir) begin
        pdir_reg <= (avs_writedata_i[NPIN-1:0] & ~claimed) | (pdir_reg & claimed);
      end
    end
  end

  // start request held until a converter clock takes it
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      pend_reg <= 1'b0;
    end else if (scr_wr) begin
      pend_reg <= avs_writedata_i[sadc_pkg::SEL_W-1:0] != sadc_pkg::SEL_POWER_OFF;
    end else if (!powered) begin
      pend_reg <= 1'b0;
    end else if (stop_i && busy) begin
      pend_reg <= 1'b1;
    end else if (sar_done && cont_reg) begin
      pend_reg <= 1'b1;
    end else if (tick && !busy) begin
      pend_reg <= 1'b0;
    end
  end

  // completion flag and interrupt; set wins
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      done_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      done_reg <= (sar_done & ~ien_reg) | (done_reg & ~flag_clr);
      irq_reg <= (sar_done & ien_reg) | (irq_reg & ~flag_clr);
    end
  end

  sadc_prescaler u_pre (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .xtal_i(xtal_i),
    .src_bus_i(clkcfg_reg[0]),
    .prescale_i(clkcfg_reg[3:1]),
    .hold_i(stop_i),
    .tick_o(tick)
  );

  // abort on stop, status write or power-off
  sadc_sar u_sar (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .tick_i(tick),
    .start_i(pend_reg & powered & ~scr_wr),
    .abort_i(stop_i | scr_wr | ~powered),
    .comp_i(comp_i),
    .busy_o(busy),
    .done_o(sar_done),
    .result_o(result),
    .dac_o(dac_code_o)
  );

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_done_plain;
    sar_done && !ien_reg;
  endsequence
  sequence s_flag_seen;
    ##1 done_reg ##1 (done_reg || $past(flag_clr));
  endsequence

  flag_set_a: assert property (s_done_plain |-> s_flag_seen)
    else $error("completion flag not set after conversion");

  irq_set_a: assert property (sar_done && ien_reg |=> irq_o && !scr_view[7])
    else $error("interrupt not raised or flag visible with interrupt enabled");

  irq_clear_a: assert property ((flag_clr && !sar_done) |=> (!irq_o && !done_reg))
    else $error("flag or interrupt survived a clear");

  pin_claim_a: assert property ((sel_reg < 5'(NPIN)) |-> !pin_oe_o[sel_reg[3:0]])
    else $error("selected pin still driven by port logic");

  port_guard_a: assert property ((acc_wr && hit_pdir && sel_reg < 5'(NPIN))
    |=> $stable(pdir_reg[sel_reg[3:0]]))
    else $error("direction write reached the selected pin");

  claim_read_a: assert property ((sel_reg < 5'(NPIN) && !pdir_reg[sel_reg[3:0]])
    |-> !pin_rd[sel_reg[3:0]])
    else $error("claimed input pin read as nonzero");

  start_tick_a: assert property ((tick && pend_reg && powered && !busy && !stop_i && !scr_wr)
    |=> busy && !pend_reg)
    else $error("conversion did not start on the converter clock");

  cont_again_a: assert property ((sar_done && cont_reg && powered && !stop_i && !scr_wr)
    |=> pend_reg)
    else $error("continuous mode did not request another conversion");

  stop_abort_a: assert property ((stop_i && busy) |=> !busy ##0 pend_reg)
    else $error("stop did not abort and hold a pending conversion");

  reset_idle_a: assert property (disable iff (1'b0) !rst_b_i
    |=> (!busy && !done_reg && !irq_o && !ien_reg && !cont_reg && !powered))
    else $error("reset did not leave the converter idle");
endmodule // sadc_top

// ===== verif/sadc_analog_src.sv
// Analog sources on the shared pins, seen through the converter comparator
`timescale 1ns/1ps
module sadc_analog_src (
  input wire logic mclk_i, // Bus clock
  input wire logic [4:0] mux_sel_i, // Selected input
  input wire logic [7:0] dac_code_i, // Trial code
  input wire logic conv_power_i, // Analog section on
  input int lvl_i [15], // Pin levels in code steps
  output logic comp_o // Input at or above trial
);
  int v;
  logic ok;
  logic junk = 1'b0;
  // Unpowered or unused selects give a comparator that keeps changing
  always @(posedge mclk_i) junk <= ~junk;
  always_comb begin
    ok = conv_power_i && (mux_sel_i < 5'h0f || mux_sel_i > 5'h1b);
    v = (mux_sel_i < 5'h0f) ? lvl_i[mux_sel_i] : 0;
    if (mux_sel_i == 5'h1c || mux_sel_i == 5'h1d) v = 255;
    // linear compare, clamps beyond the references
    comp_o = ok ? (v >= int'(dac_code_i)) : junk;
  end
endmodule // sadc_analog_src

// ===== verif/testbench.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module testbench;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, comp_i, conv_power_o, irq_o;
  logic xtal_i = 1'b0;
  logic stop_i = 1'b0;
  logic [7:0] dac_code_o;
  logic [4:0] mux_sel_o;
  logic [14:0] pin_in_i = 15'h0;
  logic [14:0] pin_out_o, pin_oe_o;
  logic [31:0] exq [$];
  int lvl [15];
  int pre [6] = '{0, 1, 2, 3, 4, 7};
  int err_total = 0;
  int n_compared = 0;
  int n, d;
  sadc_top u_sadc_top (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_byteenable_i(4'hf),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .xtal_i(xtal_i), .stop_i(stop_i), .comp_i(comp_i),
    .dac_code_o(dac_code_o), .mux_sel_o(mux_sel_o), .conv_power_o(conv_power_o),
    .irq_o(irq_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));
  sadc_analog_src u_sadc_analog_src (.mclk_i(mclk_i), .mux_sel_i(mux_sel_o),
    .dac_code_i(dac_code_o), .conv_power_i(conv_power_o), .lvl_i(lvl), .comp_o(comp_i));
  always #4 mclk_i = ~mclk_i;
  // Crystal runs at six bus clocks, edges never on a bus clock edge
  initial begin
    #3;
    forever #24 xtal_i = ~xtal_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dat);
    @(posedge mclk_i);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= a;
    avs_writedata_i <= dat;
    do begin
      @(posedge mclk_i);
    end while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wait_irq();
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (irq_o !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, irq_o, 1'b1);
    end
  endtask
  function automatic logic [31:0] clampv(input int v);
    return v > 255 ? 32'hff : (v < 0 ? 32'h0 : 32'(v));
  endfunction
  // Read data compared, oldest note first, in the accepting cycle
  always @(posedge mclk_i) begin
    if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
      chk(avs_readdata_o, exq.pop_front());
    end
  end
  task automatic wrap_up();
    $display("Compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge mclk_i);
    err_total++;
    wrap_up();
  end
  initial begin
    void'($urandom(28740));
    for (int i = 0; i < 15; i++) lvl[i] = $urandom_range(255);
    lvl[0] = 255;
    lvl[1] = 0;
    lvl[13] = 300;
    lvl[14] = -7;
    repeat (5) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    pin_in_i <= 15'($urandom);
    chk({conv_power_o, irq_o, pin_oe_o, mux_sel_o}, 32'h1f);
    rd(sadc_pkg::SCR_OFF, 32'h1f);
    rd(sadc_pkg::RES_OFF, 32'h0);
    rd(sadc_pkg::CLK_OFF, 32'h0);
    rd(8'h50, 32'h0);
    bus(1'b1, sadc_pkg::CLK_OFF, 32'h10);
    // no timer clock on pin fourteen here, so input fourteen is free
    for (int c = 0; c < 18; c++) begin
      d = c < 15 ? c : c + 13;
      bus(1'b1, sadc_pkg::SCR_OFF, 32'(32'h40 | d));
      wait_irq();
      chk({conv_power_o, mux_sel_o, 1'b0, n < 30}, {1'b1, d[4:0], 2'b01});
      rd(sadc_pkg::SCR_OFF, 32'(32'h40 | d));
      rd(sadc_pkg::RES_OFF, clampv(c < 15 ? lvl[c] : (c == 17 ? 0 : 255)));
      @(negedge mclk_i);
      chk(irq_o, 32'h0);
    end
    foreach (pre[i]) begin
      d = 1 << (pre[i] > 3 ? 4 : pre[i]);
      bus(1'b1, sadc_pkg::CLK_OFF, 32'(32'h10 | (pre[i] << 5)));
      bus(1'b1, sadc_pkg::SCR_OFF, 32'h40);
      wait_irq();
      chk(n >= 16 * d && n <= 17 * d + 3, 32'h1);
      rd(sadc_pkg::RES_OFF, 32'hff);
    end
    bus(1'b1, sadc_pkg::CLK_OFF, 32'h00);
    bus(1'b1, sadc_pkg::SCR_OFF, 32'h40);
    wait_irq();
    chk(n >= 96 && n <= 110, 32'h1);
    rd(sadc_pkg::RES_OFF, 32'hff);
    bus(1'b1, sadc_pkg::CLK_OFF, 32'h10);
    bus(1'b1, sadc_pkg::SCR_OFF, 32'h02);
    repeat (25) @(posedge mclk_i);
    chk(irq_o, 32'h0);
    rd(sadc_pkg::SCR_OFF, 32'h82);
    rd(sadc_pkg::RES_OFF, clampv(lvl[2]));
    rd(sadc_pkg::SCR_OFF, 32'h02);
    bus(1'b1, sadc_pkg::SCR_OFF, 32'h02);
    repeat (25) @(posedge mclk_i);
    bus(1'b1, sadc_pkg::SCR_OFF, 32'h02);
    rd(sadc_pkg::SCR_OFF, 32'h02);
    bus(1'b1, sadc_pkg::SCR_OFF, 32'h61);
    wait_irq();
    lvl[1] = 77;
    repeat (60) @(posedge mclk_i);
    rd(sadc_pkg::RES_OFF, 32'd77);
    bus(1'b1, sadc_pkg::SCR_OFF, 32'h41);
    wait_irq();
    rd(sadc_pkg::RES_OFF, 32'd77);
    repeat (60) @(negedge mclk_i);
    chk(irq_o, 32'h0);
    bus(1'b1, sadc_pkg::SCR_OFF, 32'h44);
    repeat (8) @(posedge mclk_i);
    stop_i <= 1'b1;
    repeat (60) @(negedge mclk_i);
    chk(irq_o, 32'h0);
    @(posedge mclk_i);
    stop_i <= 1'b0;
    wait_irq();
    chk(n <= 24, 32'h1);
    // Software lets one conversion pass after stop before trusting a result
    bus(1'b1, sadc_pkg::SCR_OFF, 32'h44);
    wait_irq();
    rd(sadc_pkg::RES_OFF, clampv(lvl[4]));
    bus(1'b1, sadc_pkg::PDIR_OFF, 32'h0008);
    bus(1'b1, sadc_pkg::PDAT_OFF, 32'h7fff);
    bus(1'b1, sadc_pkg::SCR_OFF, 32'h03);
    rd(sadc_pkg::PPIN_OFF, {17'h0, pin_in_i | 15'h0008});
    bus(1'b1, sadc_pkg::SCR_OFF, 32'h05);
    rd(sadc_pkg::PPIN_OFF, {17'h0, (pin_in_i | 15'h0008) & 15'h7fdf});
    chk(pin_oe_o, 32'h0008);
    bus(1'b1, sadc_pkg::PDIR_OFF, 32'h7fff);
    bus(1'b1, sadc_pkg::PDAT_OFF, 32'h7fff);
    rd(sadc_pkg::PPIN_OFF, 32'h7fdf);
    chk(pin_oe_o, 32'h7fdf);
    chk(pin_out_o, 32'h7fff);
    bus(1'b1, sadc_pkg::SCR_OFF, 32'h65);
    repeat (6) @(posedge mclk_i);
    rst_b_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (40) @(negedge mclk_i);
    chk({irq_o, pin_oe_o}, 32'h0);
    rd(sadc_pkg::SCR_OFF, 32'h1f);
    // Software powers the converter down before wait when no wake is needed
    bus(1'b1, sadc_pkg::SCR_OFF, 32'h1f);
    chk({conv_power_o, mux_sel_o}, 32'h1f);
    wrap_up();
  end
endmodule // testbench
